//--- common/asrp_pkg.sv
// Shared constants and carriers of the serial readout port.
// Assumes a 200 MHz pclk; APB byte addresses are word aligned.
package asrp_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_RESULT = 12'h008;
    localparam logic [11:0] ADDR_MODE = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
    localparam logic [11:0] ADDR_IRQ_EN = 12'h014;
    localparam logic [11:0] ADDR_IRQ_CLR = 12'h018;
    localparam logic [11:0] ADDR_SAMPLE = 12'h01C;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int CTRL_WIDE_BIT = 0;
    localparam int CTRL_FAULT_BIT = 1;
    localparam int STAT_READY_BIT = 7;
    localparam int STAT_FAULT_BIT = 6;
    localparam int STAT_ONE_BIT = 3;
    localparam int STAT_WL_BIT = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int IRQ_BITS = 3;
    localparam int IRQ_RESULT = 0;
    localparam int IRQ_READOUT = 1;
    localparam int IRQ_DROPPED = 2;

    // ****************************************************************
    // Serial framing
    // ****************************************************************
    localparam int RESULT_W = 24;
    localparam int NARROW_BITS = 16;
    localparam int WIDE_BITS = 24;
    localparam int CMD_BITS = 8;
    localparam logic [1:0] CMD_READ_STATUS = 2'h1;
    localparam logic [1:0] CMD_READ_MODE = 2'h2;
    localparam logic [1:0] CMD_WRITE_MODE = 2'h0;
    localparam logic [1:0] CMD_READ_DATA = 2'h3;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } asrp_pins_t;

    typedef struct packed {
        logic rise;
        logic fall;
        logic sel;
        logic din;
    } asrp_link_t;

endpackage : asrp_pkg

//--- rtl/asrp_pin_sync.sv
// Two-stage synchroniser for the host pins, with serial clock edges.
// Assumes pins are asynchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module asrp_pin_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Pins
    input wire asrp_pkg::asrp_pins_t pins,
    // Synchronised view
    output asrp_pkg::asrp_link_t link
);
    asrp_pkg::asrp_pins_t meta_reg;
    asrp_pkg::asrp_pins_t sync_reg;
    logic sclk_last_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 3'b110;
            sync_reg <= 3'b110;
            sclk_last_reg <= 1'b1;
        end else if (clk_en) begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            sclk_last_reg <= sync_reg.sclk;
        end
    end

    // One driver for the whole carrier struct
    assign link = '{
        rise: sync_reg.sclk & ~sclk_last_reg & clk_en,
        fall: ~sync_reg.sclk & sclk_last_reg & clk_en,
        sel: ~sync_reg.cs_n,
        din: sync_reg.din
    };
endmodule : asrp_pin_sync
`default_nettype wire

//--- rtl/asrp_core.sv
// Converter side of the serial readout port with APB access for results.
// Assumes APB master on pclk; host pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Low chip select selects serial access
// - Bursty or continuous clock gives same data
// - Ready low while unread result held
// - Ready returns high after full word
// - Ready stays low when a new result replaces an unread one
// - Data and ready share one pin
// - Word length bit zero narrow, one wide
// - Read-only status reports ready and fault
module asrp_core (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout_ready,
    output logic dout_ready_oe,
    input wire logic ref_power_down,
    // Interrupt and status
    output logic irq,
    output logic ref_active
);
    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    asrp_pkg::asrp_pins_t pins;
    asrp_pkg::asrp_link_t link;
    logic ref_power_down_meta_reg;
    logic ref_power_down_sync_reg;

    assign pins = '{cs_n: cs_n, sclk: sclk, din: din};

    asrp_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pins(pins),
        .link(link)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_power_down_meta_reg <= 1'b1;
            ref_power_down_sync_reg <= 1'b1;
        end else if (clk_en) begin
            ref_power_down_meta_reg <= ref_power_down;
            ref_power_down_sync_reg <= ref_power_down_meta_reg;
        end
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [1:0] ctrl_reg;
    logic [7:0] mode_reg;
    logic [23:0] result_reg;
    logic [23:0] sample_reg;
    logic valid_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_en_reg;
    logic [23:0] shift_reg;
    logic [4:0] count_reg;
    logic [7:0] cmd_reg;
    logic [1:0] cmd_kind_reg;
    logic wide;
    logic [4:0] word_bits;
    logic [7:0] status_byte;

    typedef enum logic [1:0] {ASRP_CMD, ASRP_OUT, ASRP_IN} asrp_state_t;
    asrp_state_t state_reg;
    asrp_state_t state_next;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic apb_wr;
    logic apb_rd;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_result;
    logic hit_mode;
    logic hit_istat;
    logic hit_ien;
    logic hit_iclr;
    logic hit_sample;
    logic hit_any;
    logic sample_load;

    assign apb_wr = psel & penable & pwrite & clk_en;
    assign apb_rd = psel & penable & ~pwrite & clk_en;
    assign hit_ctrl = paddr == asrp_pkg::ADDR_CTRL;
    assign hit_stat = paddr == asrp_pkg::ADDR_STAT;
    assign hit_result = paddr == asrp_pkg::ADDR_RESULT;
    assign hit_mode = paddr == asrp_pkg::ADDR_MODE;
    assign hit_istat = paddr == asrp_pkg::ADDR_IRQ_STAT;
    assign hit_ien = paddr == asrp_pkg::ADDR_IRQ_EN;
    assign hit_iclr = paddr == asrp_pkg::ADDR_IRQ_CLR;
    assign hit_sample = paddr == asrp_pkg::ADDR_SAMPLE;
    assign hit_any = hit_ctrl | hit_stat | hit_result | hit_mode | hit_istat | hit_ien
        | hit_iclr | hit_sample;
    assign sample_load = apb_wr & hit_sample;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    assign wide = ctrl_reg[asrp_pkg::CTRL_WIDE_BIT];
    assign word_bits = wide ? 5'(asrp_pkg::WIDE_BITS) : 5'(asrp_pkg::NARROW_BITS);

    // Ready flag is active low in the status byte, as on the pin
    assign status_byte = {~valid_reg, ctrl_reg[asrp_pkg::CTRL_FAULT_BIT], 2'b00, 1'b1,
        wide, 2'b00};

    logic [31:0] rd_mux;
    assign rd_mux = hit_ctrl ? {30'h0, ctrl_reg}
        : hit_stat ? {24'h0, status_byte}
        : hit_result ? {8'h0, result_reg}
        : hit_mode ? {24'h0, mode_reg}
        : hit_istat ? {29'h0, irq_stat_reg}
        : hit_ien ? {29'h0, irq_en_reg}
        : hit_sample ? {8'h0, sample_reg}
        : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= asrp_pkg::CTRL_RESET;
            irq_en_reg <= 3'h0;
            sample_reg <= 24'h0000;
        end else if (apb_wr) begin
            if (hit_ctrl) begin
                ctrl_reg <= pwdata[1:0];
            end
            if (hit_ien) begin
                irq_en_reg <= pwdata[2:0];
            end
            if (hit_sample) begin
                sample_reg <= pwdata[23:0];
            end
        end
    end

    // ****************************************************************
    // Serial engine
    // ****************************************************************
    logic word_done;
    logic cmd_done;
    logic in_done;
    logic readout_done;

    assign cmd_done = state_reg == ASRP_CMD && link.rise && count_reg == 5'(asrp_pkg::CMD_BITS - 1);
    assign in_done = state_reg == ASRP_IN && link.rise && count_reg == 5'(asrp_pkg::CMD_BITS - 1);
    assign word_done = state_reg == ASRP_OUT && link.rise
        && count_reg == (cmd_kind_reg == asrp_pkg::CMD_READ_DATA ? word_bits - 5'd1
        : 5'(asrp_pkg::CMD_BITS - 1));
    assign readout_done = word_done && cmd_kind_reg == asrp_pkg::CMD_READ_DATA;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ASRP_CMD: begin
                if (cmd_done) begin
                    state_next = (cmd_reg[4:3] == asrp_pkg::CMD_WRITE_MODE) ? ASRP_IN : ASRP_OUT;
                end
            end
            ASRP_OUT: begin
                if (word_done) begin
                    state_next = ASRP_CMD;
                end
            end
            ASRP_IN: begin
                if (in_done) begin
                    state_next = ASRP_CMD;
                end
            end
            default: state_next = ASRP_CMD;
        endcase
    end

    logic [23:0] load_word;
    always_comb begin
        case (cmd_reg[4:3])
            asrp_pkg::CMD_READ_STATUS: load_word = {status_byte, 16'h0000};
            asrp_pkg::CMD_READ_MODE: load_word = {mode_reg, 16'h0000};
            asrp_pkg::CMD_READ_DATA: load_word = wide ? result_reg : {result_reg[15:0], 8'h00};
            default: load_word = 24'h0000;
        endcase
    end

    // Counting only serial edges makes stalls between bursts harmless
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ASRP_CMD;
            count_reg <= 5'd0;
            cmd_reg <= 8'h00;
            cmd_kind_reg <= 2'h0;
            shift_reg <= 24'h0000;
            mode_reg <= asrp_pkg::MODE_RESET;
        end else if (clk_en) begin
            if (!link.sel) begin
                state_reg <= ASRP_CMD;
                count_reg <= 5'd0;
            end else if (link.rise) begin
                state_reg <= state_next;
                count_reg <= (state_next != state_reg) ? 5'd0 : count_reg + 5'd1;
                if (state_reg == ASRP_CMD) begin
                    cmd_reg <= {cmd_reg[6:0], link.din};
                    if (cmd_done) begin
                        cmd_kind_reg <= cmd_reg[4:3];
                        shift_reg <= load_word;
                    end
                end else if (state_reg == ASRP_OUT) begin
                    shift_reg <= {shift_reg[22:0], 1'b0};
                end else begin
                    shift_reg <= {shift_reg[22:0], link.din};
                    if (in_done) begin
                        mode_reg <= {shift_reg[6:0], link.din};
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Result valid flag and shared pin
    // ****************************************************************
    // A new sample arms ready, also over an unread one; only a full word read clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_reg <= 1'b0;
            result_reg <= 24'h0000;
        end else if (clk_en) begin
            if (sample_load) begin
                result_reg <= pwdata[23:0];
                valid_reg <= 1'b1;
            end else if (readout_done) begin
                valid_reg <= 1'b0;
            end
        end
    end

    // Pin shows data bit while shifting a word, else the active-low ready flag
    assign dout_ready = (link.sel && state_reg == ASRP_OUT) ? shift_reg[23] : ~valid_reg;
    assign dout_ready_oe = link.sel;
    assign ref_active = ~ref_power_down_sync_reg;

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [2:0] irq_event;
    assign irq_event = {sample_load & valid_reg, readout_done, sample_load};

    genvar g;
    generate
        for (g = 0; g < asrp_pkg::IRQ_BITS; g++) begin : g_irq
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_stat_reg[g] <= 1'b0;
                end else if (clk_en) begin
                    if (irq_event[g]) begin
                        irq_stat_reg[g] <= 1'b1;
                    end else if (apb_wr && hit_iclr && pwdata[g]) begin
                        irq_stat_reg[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign irq = |(irq_stat_reg & irq_en_reg);
endmodule : asrp_core
`default_nettype wire

//--- verif/asrp_chk.sv
// Concurrent checks on the ports of the serial readout port core.
// Bound onto asrp_core from the testbench top file.
`timescale 1ns/100ps
`default_nettype none
module asrp_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic cs_n,
    input wire logic dout_ready,
    input wire logic dout_ready_oe,
    input wire logic ref_power_down,
    input wire logic irq,
    input wire logic ref_active
);
    wire logic mapped;
    assign mapped = paddr[1:0] == 2'h0 && paddr <= asrp_pkg::ADDR_SAMPLE;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_cs_idle;
        cs_n [*5];
    endsequence
    property p_zero_wait;
        s_acc |-> pready;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("access not answered");
    property p_unmapped;
        s_acc ##0 !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_stat;
        s_acc ##0 (!pwrite && paddr == asrp_pkg::ADDR_STAT)
            |-> prdata[5:3] == 3'h1 && prdata[1:0] == 2'h0;
    endproperty
    a_stat: assert property (p_stat) else $error("status fixed bits wrong");
    property p_sel_off;
        s_cs_idle |-> !dout_ready_oe;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("pin driven while deselected");
    property p_sel_on;
        !cs_n [*5] |-> dout_ready_oe;
    endproperty
    a_sel_on: assert property (p_sel_on) else $error("pin not driven while selected");
    property p_ready_low;
        s_cs_idle ##0 (psel && penable && pwrite && paddr == asrp_pkg::ADDR_SAMPLE)
            |-> ##[1:2] !dout_ready;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready not low on result");
    property p_ready_hold;
        s_cs_idle ##0 !dout_ready |=> !dout_ready;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready rose unread");
    property p_ref;
        ref_power_down [*5] |-> !ref_active;
    endproperty
    a_ref: assert property (p_ref) else $error("reference active in shutdown");
    property p_irq_mask;
        s_acc ##0 (pwrite && paddr == asrp_pkg::ADDR_IRQ_EN && pwdata[2:0] == 3'h0) |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt high");
endmodule : asrp_chk
`default_nettype wire

//--- verif/asrp_host.sv
// Host model bit-banging the converter's serial pins.
// Assumes the bench calls frame() and sets ref_power_down.
`timescale 1ns/100ps
`default_nettype none
module asrp_host (
    // Host pins
    output logic cs_n,
    output logic sclk,
    output logic din,
    output logic ref_power_down,
    // Shared data and ready pin
    input wire logic dout_ready,
    input wire logic dout_ready_oe
);
    wire logic pin;
    assign pin = dout_ready_oe ? dout_ready : 1'b1;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
        ref_power_down = 1'b1;
    end
    // Shifts tx MSB first; bits after the command come back in rx
    task automatic frame(input logic [15:0] tx, input int nbit, input int gap,
            output logic [23:0] rx);
        rx = 24'h00_0000;
        cs_n = 1'b0;
        #100;
        for (int i = 0; i < nbit; i++) begin
            sclk = 1'b0;
            din = (i < 16) ? tx[15 - i] : ~din;
            #62.5;
            if (i >= 8) rx = {rx[22:0], pin};
            sclk = 1'b1;
            #62.5;
            if (i == 12) #gap;
        end
        #100;
        cs_n = 1'b1;
        din = ~din;
        // Deselect gap so back-to-back frames are seen apart
        #100;
    endtask : frame
endmodule : asrp_host
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the serial readout port core.
// Assumes asrp_chk and asrp_host are compiled first.
`timescale 1ns/100ps
`default_nettype none
bind asrp_core asrp_chk asrp_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cs_n(cs_n), .dout_ready(dout_ready), .dout_ready_oe(dout_ready_oe),
    .ref_power_down(ref_power_down), .irq(irq), .ref_active(ref_active)
);
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, cs_n, sclk, din, dout_ready, dout_ready_oe;
    logic ref_power_down, irq, ref_active, serr;
    logic [23:0] rx;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #2.5 pclk = ~pclk;
    asrp_core asrp_core_i (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .din(din), .dout_ready(dout_ready),
        .dout_ready_oe(dout_ready_oe), .ref_power_down(ref_power_down), .irq(irq),
        .ref_active(ref_active)
    );
    asrp_host asrp_host_i (
        .cs_n(cs_n), .sclk(sclk), .din(din), .ref_power_down(ref_power_down),
        .dout_ready(dout_ready), .dout_ready_oe(dout_ready_oe)
    );
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic t_power_up;
        apb(1'b0, asrp_pkg::ADDR_STAT, 32'h0);
        chk("status", rd, 32'h0000_0088);
        chk("idle pin", dout_ready, 32'h1);
        asrp_host_i.frame(16'h1000, 16, 0, rx);
        chk("serial status", rx[7:0], 32'h88);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", serr, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, asrp_pkg::ADDR_STAT, 32'h0000_00FF);
        apb(1'b0, asrp_pkg::ADDR_STAT, 32'h0);
        chk("status ro", rd, 32'h0000_0088);
        apb(1'b1, asrp_pkg::ADDR_CTRL, 32'h0000_0003);
        apb(1'b0, asrp_pkg::ADDR_STAT, 32'h0);
        chk("wide status", rd, 32'h0000_00CC);
        $display("test power_up done");
    endtask : t_power_up
    task automatic t_mode;
        asrp_host_i.frame(16'h00A5, 16, 0, rx);
        asrp_host_i.frame(16'h2000, 16, 0, rx);
        chk("mode back", rx[7:0], 32'hA5);
        apb(1'b0, asrp_pkg::ADDR_MODE, 32'h0);
        chk("mode reg", rd, 32'h0000_00A5);
        $display("test mode done");
    endtask : t_mode
    task automatic t_readout;
        apb(1'b1, asrp_pkg::ADDR_IRQ_EN, 32'h0000_0007);
        apb(1'b1, asrp_pkg::ADDR_SAMPLE, 32'h0012_3456);
        chk("ready low", dout_ready, 32'h0);
        chk("irq new", irq, 32'h1);
        asrp_host_i.frame(16'h3000, 32, 400, rx);
        chk("data", rx, 32'h0012_3456);
        chk("ready back", dout_ready, 32'h1);
        apb(1'b0, asrp_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("irq flags", rd, 32'h0000_0003);
        apb(1'b1, asrp_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
        chk("irq clear", irq, 32'h0);
        $display("test readout done");
    endtask : t_readout
    task automatic t_overrun;
        apb(1'b1, asrp_pkg::ADDR_SAMPLE, 32'h0000_AAAA);
        apb(1'b1, asrp_pkg::ADDR_SAMPLE, 32'h0000_BBBB);
        chk("still low", dout_ready, 32'h0);
        apb(1'b0, asrp_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("drop flag", rd, 32'h0000_0005);
        apb(1'b0, asrp_pkg::ADDR_RESULT, 32'h0);
        chk("latest", rd, 32'h0000_BBBB);
        apb(1'b1, asrp_pkg::ADDR_CTRL, 32'h0000_0000);
        asrp_host_i.frame(16'h3000, 24, 0, rx);
        chk("narrow data", rx[15:0], 32'h0000_BBBB);
        chk("narrow done", dout_ready, 32'h1);
        apb(1'b1, asrp_pkg::ADDR_IRQ_EN, 32'h0);
        chk("masked", irq, 32'h0);
        asrp_host_i.ref_power_down = 1'b0;
        repeat (6) @(posedge pclk);
        chk("ref on", ref_active, 32'h1);
        $display("test overrun done");
    endtask : t_overrun
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test;
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_power_up;
        t_mode;
        t_readout;
        t_overrun;
        end_of_test;
    end
endmodule : testbench
`default_nettype wire
